// File: flash_status_config_registers.sv
// Purpose: Status and configuration registers of a quad serial flash
// Assumes: Event inputs are one-cycle pulses from the command decoder
// Notes: Nonvolatile bits are loaded from the nv_* inputs at reset
//
// Functional notes
// - Busy shown in status bits 0 and 7
// - Latch clear rejects program, erase, protection writes
// - Latch cleared by listed commands and completions
// - Erase suspend flag set/cleared by suspend/resume
// - Program suspend flag set/cleared by suspend/resume
// - Lock-down flag sticky until power cycle
// - Security lock flag sticky, nonvolatile
// - Status bit 6 reads zero
// - Status readable, never written, while busy
// - Config bit 1 selects protect/pause or quad lines
// - Quad commands invalid unless selector set
// - Selector ignored in four-wire command mode
// - Selector reset value from variant strap
// - Config bit 3 low once permanently locked
// - Config bit 7 nonvolatile protect pin enable
// - Hardware protect: pin low, enable set and protect/pause pins on
// - Pin enable change runs timed busy cycle
`timescale 1ns/1ns
`default_nettype none
`include "flash_status_config_regs.svh"
module flash_status_config_registers #(
  parameter int PIN_EN_WRITE_NS = `PIN_EN_WRITE_NS
) (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  input wire logic wp_n_in,
  input wire logic io_sel_default_in,
  input wire logic nv_pin_en_in,
  input wire logic nv_sec_locked_in,
  input wire logic nv_perm_locked_in,
  input wire logic four_wire_command_mode_in,
  input wire logic soft_reset_in,
  input wire logic write_enable_cmd_in,
  input wire logic write_disable_cmd_in,
  input wire logic array_op_req_in,
  input wire logic array_busy_in,
  input wire logic array_op_is_erase_in,
  input wire logic array_op_done_in,
  input wire logic suspend_cmd_in,
  input wire logic resume_cmd_in,
  input wire logic protection_freeze_cmd_in,
  input wire logic protection_register_write_cmd_in,
  input wire logic sec_lockout_done_in,
  input wire logic perm_lock_set_in,
  input wire logic quad_cmd_in,
  output logic miso_out,
  output logic miso_oe_out,
  output logic [7:0] status_out,
  output logic [7:0] config_out,
  output logic command_rejected_out,
  output logic hw_protect_out,
  output logic protect_pause_pins_on_out
);
  localparam logic [`TIMER_W-1:0] PIN_EN_CYCLES =
    `TIMER_W'((PIN_EN_WRITE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);
  flash_reg_pkg::reg_state_t q, d;
  serial_link_if lnk ();
  logic wel_clear;
  logic gated_req;

  serial_shifter shifter_u (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .sck_in(sck_in),
    .cs_n_in(cs_n_in),
    .mosi_in(mosi_in),
    .lnk(lnk.shifter),
    .miso_out(miso_out),
    .miso_oe_out(miso_oe_out)
  );

  function automatic logic [7:0] status_of(flash_reg_pkg::reg_state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[`ST_BUSY_LO] = s.busy;
    v[`ST_BUSY_HI] = s.busy;
    v[`ST_WR_LATCH] = s.write_enable_latch;
    v[`ST_ERASE_SUSP] = s.erase_susp;
    v[`ST_PROG_SUSP] = s.prog_susp;
    v[`ST_LOCKDOWN] = s.lockdown;
    v[`ST_SEC] = s.sec;
    v[`ST_RESERVED] = 1'b0;
    return v;
  endfunction

  function automatic logic [7:0] config_of(flash_reg_pkg::reg_state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[`CF_IO_SEL] = s.io_sel;
    v[`CF_LOCK_ABSENT] = s.lock_absent;
    v[`CF_PIN_EN] = s.pin_en;
    return v;
  endfunction

  always_comb
  begin
    d = q;
    d.reject = 1'b0;
    d.wp_sy = {q.wp_sy[1:0], wp_n_in};
    if (q.wp_sy[1] == q.wp_sy[2])
      d.wp_f = q.wp_sy[2];
    // Selector only matters in single-wire mode; four-wire mode kills both pins
    d.pins_on = ~q.io_sel & ~four_wire_command_mode_in;
    d.hw_prot = ~q.wp_f & q.pin_en & d.pins_on;
    if (q.timer != '0)
      d.timer = q.timer - `TIMER_W'(1);
    // Program, erase and protection requests need the latch
    gated_req = array_op_req_in | protection_freeze_cmd_in
      | protection_register_write_cmd_in;
    if (gated_req & ~q.write_enable_latch)
      d.reject = 1'b1;
    if (quad_cmd_in & ~four_wire_command_mode_in & ~q.io_sel)
      d.reject = 1'b1;
    if (protection_freeze_cmd_in & q.write_enable_latch)
      d.lockdown = 1'b1;
    if (sec_lockout_done_in)
      d.sec = 1'b1;
    if (perm_lock_set_in)
      d.lock_absent = 1'b0;
    // Resume clears, but a suspend in the same cycle wins
    if (resume_cmd_in)
    begin
      d.erase_susp = 1'b0;
      d.prog_susp = 1'b0;
    end
    if (suspend_cmd_in & array_busy_in & array_op_is_erase_in)
      d.erase_susp = 1'b1;
    if (suspend_cmd_in & array_busy_in & ~array_op_is_erase_in)
      d.prog_susp = 1'b1;
    wel_clear = soft_reset_in | write_disable_cmd_in | array_op_done_in
      | sec_lockout_done_in | suspend_cmd_in | protection_freeze_cmd_in
      | protection_register_write_cmd_in;
    if (lnk.frame_start)
      d.op = flash_reg_pkg::OP_CMD;
    if (lnk.byte_valid)
    begin
      case (q.op)
        flash_reg_pkg::OP_CMD:
        begin
          d.op = flash_reg_pkg::OP_SKIP;
          if (lnk.rx_byte == `OP_READ_STATUS)
          begin
            d.op = flash_reg_pkg::OP_RD_ST;
            d.tx = q.st_o;
          end
          if (lnk.rx_byte == `OP_READ_CONFIG)
          begin
            d.op = flash_reg_pkg::OP_RD_CF;
            d.tx = q.cf_o;
          end
          if (lnk.rx_byte == `OP_WRITE_STATUS)
          begin
            // Writes are rejected until the internal write ends
            if (q.write_enable_latch & ~q.busy)
              d.op = flash_reg_pkg::OP_WR_ST;
            else
              d.reject = 1'b1;
          end
        end
        flash_reg_pkg::OP_RD_ST:
          d.tx = q.st_o;
        flash_reg_pkg::OP_RD_CF:
          d.tx = q.cf_o;
        flash_reg_pkg::OP_WR_ST:
          d.op = flash_reg_pkg::OP_WR_CF;
        flash_reg_pkg::OP_WR_CF:
        begin
          d.op = flash_reg_pkg::OP_SKIP;
          wel_clear = 1'b1;
          if (~q.hw_prot)
          begin
            d.io_sel = lnk.rx_byte[`CF_IO_SEL];
            d.pin_en = lnk.rx_byte[`CF_PIN_EN];
            if (lnk.rx_byte[`CF_PIN_EN] != q.pin_en)
              d.timer = PIN_EN_CYCLES;
          end
          else
            d.reject = 1'b1;
        end
        default:
          d.op = flash_reg_pkg::OP_SKIP;
      endcase
    end
    if (wel_clear)
      d.write_enable_latch = 1'b0;
    if (write_enable_cmd_in)
      d.write_enable_latch = 1'b1;
    d.busy = array_busy_in | (d.timer != '0);
    if (srst_in)
    begin
      d = '0;
      d.wp_sy = 3'h7;
      d.wp_f = 1'b1;
      d.io_sel = io_sel_default_in;
      d.pin_en = nv_pin_en_in;
      d.sec = nv_sec_locked_in;
      d.lock_absent = ~nv_perm_locked_in;
      d.op = flash_reg_pkg::OP_IDLE;
    end
    // Both bytes come from the same next state, so a read is coherent
    d.st_o = status_of(d);
    d.cf_o = config_of(d);
  end

  always_ff @(posedge clock_in)
  begin
    q <= d;
  end

  assign lnk.tx_byte = q.tx;
  assign lnk.tx_en = (q.op == flash_reg_pkg::OP_RD_ST) | (q.op == flash_reg_pkg::OP_RD_CF);
  assign status_out = q.st_o;
  assign config_out = q.cf_o;
  assign command_rejected_out = q.reject;
  assign hw_protect_out = q.hw_prot;
  assign protect_pause_pins_on_out = q.pins_on;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);

  busy_shown_a: assert property (array_busy_in |=> status_out[`ST_BUSY_LO]
    && status_out[`ST_BUSY_HI]) else $error("busy not shown in both bits");
  wel_gate_a: assert property ((array_op_req_in && !q.write_enable_latch)
    |=> command_rejected_out) else $error("request without latch not rejected");
  wel_clear_a: assert property ((write_disable_cmd_in && !write_enable_cmd_in)
    |=> !status_out[`ST_WR_LATCH]) else $error("latch not cleared");
  erase_susp_a: assert property ((suspend_cmd_in && array_busy_in
    && array_op_is_erase_in) |=> status_out[`ST_ERASE_SUSP])
    else $error("erase suspend flag missing");
  prog_susp_a: assert property ((suspend_cmd_in && array_busy_in
    && !array_op_is_erase_in) |=> status_out[`ST_PROG_SUSP])
    else $error("program suspend flag missing");
  lockdown_sticky_a: assert property (status_out[`ST_LOCKDOWN]
    |=> status_out[`ST_LOCKDOWN]) else $error("lock-down flag dropped");
  sec_sticky_a: assert property (status_out[`ST_SEC] |=> status_out[`ST_SEC])
    else $error("security flag dropped");
  res_zero_a: assert property (!status_out[`ST_RESERVED])
    else $error("reserved status bit set");
  quad_reject_a: assert property ((quad_cmd_in && !four_wire_command_mode_in
    && !q.io_sel) |=> command_rejected_out) else $error("quad command accepted");
  lock_absent_a: assert property (!config_out[`CF_LOCK_ABSENT]
    |=> !config_out[`CF_LOCK_ABSENT]) else $error("permanent lock indication cleared");
  hw_prot_a: assert property (hw_protect_out |-> $past(q.pin_en)
    && !$past(q.wp_f)) else $error("protect without pin low and enable");
  pin_busy_a: assert property ((q.timer == PIN_EN_CYCLES) |=> status_out[`ST_BUSY_LO]
    [*2]) else $error("pin enable write not busy");
  cf_res_a: assert property ((config_out & 8'h75) == 8'h00)
    else $error("reserved config bits set");

  // Serial write path, pin routing and flag lifetimes
  pins_on_a: assert property (
    (!q.io_sel && !four_wire_command_mode_in)
    |=> protect_pause_pins_on_out)
    else $error("protect and pause pins not enabled");
  pins_off_a: assert property (
    (q.io_sel || four_wire_command_mode_in)
    |=> !protect_pause_pins_on_out)
    else $error("protect and pause pins still enabled");
  latch_set_a: assert property (
    write_enable_cmd_in
    |=> status_out[`ST_WR_LATCH])
    else $error("latch not set");
  freeze_gate_a: assert property (
    (protection_freeze_cmd_in && !q.write_enable_latch && !q.lockdown)
    |=> !status_out[`ST_LOCKDOWN] && command_rejected_out)
    else $error("lock-down accepted without latch");
  resume_clear_a: assert property (
    (resume_cmd_in && !suspend_cmd_in)
    |=> !status_out[`ST_ERASE_SUSP] && !status_out[`ST_PROG_SUSP])
    else $error("suspend flag kept after resume");
  busy_pair_a: assert property (
    status_out[`ST_BUSY_LO] == status_out[`ST_BUSY_HI])
    else $error("busy bits disagree");
  busy_clear_a: assert property (
    (!array_busy_in && q.timer == '0 && q.op != flash_reg_pkg::OP_WR_CF)
    |=> !status_out[`ST_BUSY_LO])
    else $error("busy shown while idle");
  write_busy_a: assert property (
    (lnk.byte_valid && q.op == flash_reg_pkg::OP_CMD
    && lnk.rx_byte == `OP_WRITE_STATUS && q.busy)
    |=> command_rejected_out)
    else $error("status write accepted while busy");
  cfg_guard_a: assert property (
    (lnk.byte_valid && q.op == flash_reg_pkg::OP_WR_CF && q.hw_prot)
    |=> command_rejected_out)
    else $error("protected config write not rejected");
  sel_write_a: assert property (
    (lnk.byte_valid && q.op == flash_reg_pkg::OP_WR_CF && !q.hw_prot)
    |=> config_out[`CF_IO_SEL] == $past(lnk.rx_byte[`CF_IO_SEL]))
    else $error("selector not written");
  pin_write_a: assert property (
    (lnk.byte_valid && q.op == flash_reg_pkg::OP_WR_CF && !q.hw_prot)
    |=> config_out[`CF_PIN_EN] == $past(lnk.rx_byte[`CF_PIN_EN]))
    else $error("pin enable not written");
  write_latch_a: assert property (
    (lnk.byte_valid && q.op == flash_reg_pkg::OP_WR_CF && !write_enable_cmd_in)
    |=> !status_out[`ST_WR_LATCH])
    else $error("latch kept after status write");
  lock_set_a: assert property (
    perm_lock_set_in
    |=> !config_out[`CF_LOCK_ABSENT])
    else $error("permanent lock not shown");
  sec_set_a: assert property (
    sec_lockout_done_in
    |=> status_out[`ST_SEC])
    else $error("security lock not shown");
  pin_timer_a: assert property (
    (lnk.byte_valid && q.op == flash_reg_pkg::OP_WR_CF && !q.hw_prot
    && lnk.rx_byte[`CF_PIN_EN] != q.pin_en)
    |=> q.timer == PIN_EN_CYCLES)
    else $error("pin enable write timer not started");
  hw_prot_on_a: assert property (
    (!q.wp_f && q.pin_en && !q.io_sel && !four_wire_command_mode_in)
    |=> hw_protect_out)
    else $error("hardware protection missing");
  prot_write_gate_a: assert property (
    (protection_register_write_cmd_in && !q.write_enable_latch)
    |=> command_rejected_out)
    else $error("protection write accepted without latch");
  no_reject_a: assert property (
    (!array_op_req_in && !protection_freeze_cmd_in && !protection_register_write_cmd_in
    && !quad_cmd_in && !lnk.byte_valid)
    |=> !command_rejected_out)
    else $error("reject without cause");
  erase_hold_a: assert property (
    (status_out[`ST_ERASE_SUSP] && !resume_cmd_in)
    |=> status_out[`ST_ERASE_SUSP])
    else $error("erase suspend flag dropped");
  prog_hold_a: assert property (
    (status_out[`ST_PROG_SUSP] && !resume_cmd_in)
    |=> status_out[`ST_PROG_SUSP])
    else $error("program suspend flag dropped");

  cover_read_st_c: cover property (q.op == flash_reg_pkg::OP_RD_ST ##1 lnk.byte_valid);
  cover_cfg_wr_c: cover property (q.op == flash_reg_pkg::OP_WR_CF ##1 lnk.byte_valid);
  cover_suspend_c: cover property (status_out[`ST_ERASE_SUSP] ##1 resume_cmd_in);
  cover_hw_prot_c: cover property (hw_protect_out ##1 lnk.byte_valid);
  cover_reject_c: cover property (command_rejected_out ##1 !command_rejected_out);
endmodule
`default_nettype wire

// File: flash_status_config_regs.svh
// Purpose: Bit positions, opcodes and timing for the status/config bank
// Assumes: 100 MHz core clock
// Notes: Included by the package and the register module
`ifndef FLASH_STATUS_CONFIG_REGS_SVH
`define FLASH_STATUS_CONFIG_REGS_SVH
`define ST_BUSY_LO 0
`define ST_WR_LATCH 1
`define ST_ERASE_SUSP 2
`define ST_PROG_SUSP 3
`define ST_LOCKDOWN 4
`define ST_SEC 5
`define ST_RESERVED 6
`define ST_BUSY_HI 7
`define CF_IO_SEL 1
`define CF_LOCK_ABSENT 3
`define CF_PIN_EN 7
`define OP_READ_STATUS 8'h05
`define OP_WRITE_STATUS 8'h01
`define OP_READ_CONFIG 8'h35
`define CLK_PERIOD_NS 10
`define PIN_EN_WRITE_NS 1000
`define TIMER_W 16
`endif

// File: flash_reg_pkg.sv
// Purpose: State types of the status/config bank and its serial shifter
// Assumes: Header holds every number
// Notes: Types only
`include "flash_status_config_regs.svh"
package flash_reg_pkg;
  typedef enum logic [2:0] {OP_IDLE, OP_CMD, OP_RD_ST, OP_RD_CF, OP_WR_ST, OP_WR_CF,
    OP_SKIP} op_state_t;
  typedef struct packed {
    logic [2:0][2:0] sy;
    logic [2:0] filt;
    logic [7:0] rx;
    logic [7:0] tx;
    logic [2:0] cnt;
    logic byte_valid;
    logic frame_start;
    logic miso;
    logic oe;
  } sh_state_t;
  typedef struct packed {
    logic [2:0] wp_sy;
    logic wp_f;
    logic busy;
    logic write_enable_latch;
    logic erase_susp;
    logic prog_susp;
    logic lockdown;
    logic sec;
    logic lock_absent;
    logic io_sel;
    logic pin_en;
    logic [`TIMER_W-1:0] timer;
    op_state_t op;
    logic [7:0] tx;
    logic reject;
    logic hw_prot;
    logic pins_on;
    logic [7:0] st_o;
    logic [7:0] cf_o;
  } reg_state_t;
endpackage

// File: serial_link_if.sv
// Purpose: Byte carrier between serial shifter and register bank
// Assumes: Both ends on clock_in
// Notes: byte_valid and frame_start are one-cycle pulses
`timescale 1ns/1ns
`default_nettype none
interface serial_link_if;
  logic [7:0] rx_byte;
  logic byte_valid;
  logic frame_start;
  logic [7:0] tx_byte;
  logic tx_en;
  modport shifter (output rx_byte, output byte_valid, output frame_start,
    input tx_byte, input tx_en);
  modport regs (input rx_byte, input byte_valid, input frame_start,
    output tx_byte, output tx_en);
endinterface
`default_nettype wire

// File: serial_shifter.sv
// Purpose: Mode 0 serial byte shifter, oversampling the link pins
// Assumes: Core clock at least eight times the serial clock
// Notes: MSB first; out byte is loaded on the falling edge after a byte
`timescale 1ns/1ns
`default_nettype none
module serial_shifter (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  serial_link_if.shifter lnk,
  output logic miso_out,
  output logic miso_oe_out
);
  flash_reg_pkg::sh_state_t q, d;
  logic [2:0] pins;
  logic rise;
  logic fall;
  assign pins = {sck_in, cs_n_in, mosi_in};
  always_comb
  begin
    d = q;
    d.byte_valid = 1'b0;
    d.frame_start = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      d.sy[i] = {q.sy[i][1:0], pins[i]};
      // Only the later two stages vote, the first is metastability guard
      if (q.sy[i][1] == q.sy[i][2])
        d.filt[i] = q.sy[i][2];
    end
    rise = ~q.filt[2] & d.filt[2];
    fall = q.filt[2] & ~d.filt[2];
    if (q.filt[1] & ~d.filt[1])
    begin
      d.frame_start = 1'b1;
      d.cnt = 3'h0;
    end
    if (~d.filt[1] & rise)
    begin
      d.rx = {q.rx[6:0], d.filt[0]};
      d.cnt = q.cnt + 3'h1;
      d.byte_valid = (q.cnt == 3'h7);
    end
    if (~d.filt[1] & fall)
    begin
      d.tx = (q.cnt == 3'h0) ? lnk.tx_byte : {q.tx[6:0], 1'b0};
      d.miso = d.tx[7];
    end
    d.oe = ~d.filt[1] & lnk.tx_en;
    if (srst_in)
    begin
      d = '0;
      // Stages start at the idle pin levels, so no false edge follows reset
      d.sy[1] = 3'h7;
      d.filt = 3'h2;
    end
  end
  always_ff @(posedge clock_in)
  begin
    q <= d;
  end
  assign lnk.rx_byte = q.rx;
  assign lnk.byte_valid = q.byte_valid;
  assign lnk.frame_start = q.frame_start;
  assign miso_out = q.miso;
  assign miso_oe_out = q.oe;
endmodule
`default_nettype wire

// File: host_spi_model.sv
// Purpose: Host controller model driving the serial link in mode 0
// Assumes: 125 ns serial clock, MSB first, one byte per 8 clocks
// Notes: Clock stands still and the data line inverts outside frames
`timescale 1ns/1ns
`default_nettype none
module host_spi_model (
  output logic sck_out,
  output logic cs_n_out,
  output logic mosi_out,
  input wire logic miso_in,
  input wire logic miso_oe_in
);
  logic [7:0] rd_q;
  initial
  begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
    rd_q = 8'h00;
  end
  // Status may be polled at any time, also while an array operation runs
  task automatic frame(input logic [23:0] tx, input int n);
    // Offset from the core clock so no link edge lands on a sampling edge
    #2 cs_n_out = 1'b0;
    for (int i = 0; i < 8 * n; i++)
    begin
      mosi_out = tx[23 - i];
      #62 sck_out = 1'b1;
      // An undriven line must never pass for valid data
      rd_q = {rd_q[6:0], miso_oe_in ? miso_in : 1'bx};
      #63 sck_out = 1'b0;
    end
    #60 cs_n_out = 1'b1;
    mosi_out = ~mosi_out;
    #100;
  endtask
endmodule
`default_nettype wire

// File: tb_flash_status_config_registers.sv
// Purpose: Self-checking bench of the status and configuration bank
// Assumes: Inputs other than the serial link pins change on the falling clock edge
// Notes: Driver queues expected values, a monitor compares them
`timescale 1ns/1ns
`default_nettype none
module tb_flash_status_config_registers;
  typedef struct {
    int sel;
    logic [7:0] val;
  } note_t;
  logic clock_in, srst_in, sck, cs_n, mosi, wp_n, io_def, nv_pin, nv_sec, nv_perm;
  logic four_wire, busy, is_erase, miso, miso_oe, rej, hwp, pins_on;
  logic [11:0] ev;
  logic [7:0] st, cf;
  logic [7:0] obs [6];
  logic [31:0] rnd;
  note_t exp_q [$];
  int err_total, n_tests, seed;

  flash_status_config_registers #(
    .PIN_EN_WRITE_NS(1000)
  ) flash_status_config_registers_i (
    .clock_in(clock_in), .srst_in(srst_in), .sck_in(sck), .cs_n_in(cs_n),
    .mosi_in(mosi), .wp_n_in(wp_n), .io_sel_default_in(io_def),
    .nv_pin_en_in(nv_pin), .nv_sec_locked_in(nv_sec), .nv_perm_locked_in(nv_perm),
    .four_wire_command_mode_in(four_wire), .soft_reset_in(ev[0]),
    .write_enable_cmd_in(ev[1]), .write_disable_cmd_in(ev[2]), .array_op_req_in(ev[3]),
    .array_busy_in(busy), .array_op_is_erase_in(is_erase), .array_op_done_in(ev[4]),
    .suspend_cmd_in(ev[5]), .resume_cmd_in(ev[6]), .protection_freeze_cmd_in(ev[7]),
    .protection_register_write_cmd_in(ev[8]), .sec_lockout_done_in(ev[9]),
    .perm_lock_set_in(ev[10]), .quad_cmd_in(ev[11]), .miso_out(miso),
    .miso_oe_out(miso_oe), .status_out(st), .config_out(cf),
    .command_rejected_out(rej), .hw_protect_out(hwp), .protect_pause_pins_on_out(pins_on)
  );

  host_spi_model host_spi_model_i (
    .sck_out(sck), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso), .miso_oe_in(miso_oe)
  );

  initial
  begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  always_comb
  begin
    obs[0] = st;
    obs[1] = cf;
    obs[2] = {7'h00, rej};
    obs[3] = {7'h00, hwp};
    obs[4] = {7'h00, pins_on};
    obs[5] = host_spi_model_i.rd_q;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic note(input int sel, input logic [7:0] val);
    exp_q.push_back('{sel, val});
  endtask

  // The oldest note always belongs to the output settled right now
  initial
  begin
    note_t n;
    forever
    begin
      wait (exp_q.size() != 0);
      n = exp_q.pop_front();
      check(obs[n.sel], n.val);
    end
  end

  task automatic pulse(input int b);
    ev[b] = 1'b1;
    @(negedge clock_in);
    ev = 12'h000;
  endtask

  task automatic do_reset(input logic [3:0] nv);
    {io_def, nv_pin, nv_sec, nv_perm} = nv;
    srst_in = 1'b1;
    repeat (5) @(negedge clock_in);
    srst_in = 1'b0;
    repeat (2) @(negedge clock_in);
  endtask

  task automatic write_cfg(input logic we, input logic [7:0] v);
    if (we)
      pulse(1);
    host_spi_model_i.frame({8'h01, rnd[15:8], v}, 3);
    @(negedge clock_in);
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Whole sequence needs about 21 us; the limit leaves a wide margin
  initial
  begin
    #400000;
    err_total++;
    end_sim;
  end

  initial
  begin
    {srst_in, wp_n, four_wire, busy, is_erase, io_def, nv_pin, nv_sec, nv_perm} = 9'h180;
    ev = 12'h000;
    rnd = 32'h00000000;
    seed = 32'hC34D;
    @(negedge clock_in);
    do_reset(4'h0);
    note(0, 8'h00);
    note(1, 8'h08);
    note(4, 8'h01);
    pulse(7);
    note(2, 8'h01);
    note(0, 8'h00);
    pulse(11);
    note(2, 8'h01);
    pulse(1);
    note(0, 8'h02);
    pulse(2);
    note(0, 8'h00);
    pulse(1);
    pulse(0);
    note(0, 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      is_erase = (k == 0);
      pulse(1);
      pulse(3);
      note(2, 8'h00);
      busy = 1'b1;
      repeat (2) @(negedge clock_in);
      note(0, 8'h83);
      host_spi_model_i.frame({8'h05, rnd[15:0]}, 2);
      @(negedge clock_in);
      note(5, 8'h83);
      pulse(5);
      busy = 1'b0;
      @(negedge clock_in);
      note(0, (k == 0) ? 8'h04 : 8'h08);
      pulse(6);
      busy = 1'b1;
      repeat (2) @(negedge clock_in);
      note(0, 8'h81);
      pulse(4);
      busy = 1'b0;
      repeat (2) @(negedge clock_in);
      note(0, 8'h00);
    end
    pulse(1);
    pulse(7);
    note(2, 8'h00);
    note(0, 8'h10);
    pulse(0);
    note(0, 8'h10);
    pulse(1);
    pulse(8);
    note(0, 8'h10);
    pulse(9);
    note(0, 8'h30);
    do_reset(4'hF);
    note(0, 8'h20);
    note(1, 8'h82);
    note(4, 8'h00);
    do_reset(4'h0);
    rnd = $random(seed);
    write_cfg(1'b1, {1'b1, rnd[6:2], 1'b1, rnd[0]});
    note(0, 8'h81);
    note(1, 8'h8A);
    note(4, 8'h00);
    pulse(11);
    note(2, 8'h00);
    repeat (120) @(negedge clock_in);
    note(0, 8'h00);
    rnd = $random(seed);
    write_cfg(1'b1, {1'b1, rnd[6:2], 1'b0, rnd[0]});
    note(1, 8'h88);
    note(4, 8'h01);
    wp_n = 1'b0;
    repeat (8) @(negedge clock_in);
    note(3, 8'h01);
    write_cfg(1'b1, 8'h02);
    note(1, 8'h88);
    note(0, 8'h00);
    four_wire = 1'b1;
    repeat (8) @(negedge clock_in);
    note(3, 8'h00);
    note(4, 8'h00);
    pulse(11);
    note(2, 8'h00);
    four_wire = 1'b0;
    wp_n = 1'b1;
    write_cfg(1'b0, 8'h02);
    note(1, 8'h88);
    host_spi_model_i.frame({8'h35, rnd[15:0]}, 2);
    @(negedge clock_in);
    note(5, 8'h88);
    pulse(10);
    note(1, 8'h80);
    repeat (4) @(negedge clock_in);
    end_sim;
  end
endmodule
`default_nettype wire
